// ---- hdl/sfm_mode_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
module sfm_mode_ctrl
  import sfm_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  input  wire sfm_pkg::sfm_apb_req_t  apbReq,
  output logic                        pready,
  output logic                        pslverr,
  output logic [sfm_pkg::DATA_W-1:0]  prdata,
  input  wire logic                   autoLoadValid,
  input  wire logic [sfm_pkg::DATA_W-1:0] autoLoadData,
  input  wire logic                   rxPolarityInvertOffStrap,
  input  wire sfm_pkg::sfm_pkt_t      pktIn,
  output logic                        fwdValid,
  output logic [sfm_pkg::LEN_W-1:0]   fwdStartCycle,
  input  wire logic [sfm_pkg::NPORT-1:0] portReq,
  input  wire logic [sfm_pkg::NPORT-1:0] portCreditOk,
  output logic [sfm_pkg::NPORT-1:0]   portGrant,
  input  wire logic [sfm_pkg::NCRED-1:0] creditPend,
  output logic [sfm_pkg::NCRED-1:0]   creditRel,
  output var sfm_pkg::sfm_mode_t      modeOut
);
  import sfm_pkg::*;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  sfm_mode_t         mode_ff;
  sfm_mode_t         nxt_mode;
  logic              strapPending_ff;
  logic [DATA_W-1:0] prdata_ff;
  logic [DATA_W-1:0] byteMask;
  logic [DATA_W-1:0] wrMask;
  logic              setupPh;
  logic              accessPh;
  logic              hit;
  logic              wrEn;

  assign setupPh  = apbReq.psel & ~apbReq.penable;
  assign accessPh = apbReq.psel & apbReq.penable;
  assign hit      = (apbReq.paddr == MODE_OFFSET);
  assign wrEn     = accessPh & apbReq.pwrite & hit;
  assign pready   = 1'b1;
  assign pslverr  = accessPh & ~hit;
  assign prdata   = prdata_ff;
  assign modeOut  = mode_ff;

  genvar gb;
  generate
    for (gb = 0; gb < STRB_W; gb++)
    begin : g_lane
      assign byteMask[8*gb +: 8] = {8{apbReq.pstrb[gb]}};
    end
  endgenerate

  // Read-only and reserved bits are outside the write mask
  assign wrMask = byteMask & SW_WR_MASK;

  always_comb
  begin
    nxt_mode = mode_ff;
    if (strapPending_ff)
    begin
      nxt_mode.rxPolarityInvertOffStrap = rxPolarityInvertOffStrap;
    end
    if (wrEn)
    begin
      // Built on nxt_mode so a write in the strap cycle keeps the captured pin level
      nxt_mode = sfm_mode_t'((nxt_mode & ~wrMask) | (apbReq.pwdata & wrMask));
    end
    // Autoload wins over a same-cycle write so the loaded image is never torn
    if (autoLoadValid)
    begin
      nxt_mode = sfm_mode_t'(autoLoadData & LOAD_MASK);
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode_ff <= MODE_RST;
    end
    else
    begin
      mode_ff <= nxt_mode;
    end
  end

  // Strap is caught on the first edge after release, not by the reset itself
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      strapPending_ff <= 1'b1;
    end
    else
    begin
      strapPending_ff <= 1'b0;
    end
  end

  // Read data is captured in the setup phase so the access phase needs no wait
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prdata_ff <= '0;
    end
    else if (setupPh && !apbReq.pwrite && apbReq.paddr == MODE_OFFSET)
    begin
      prdata_ff <= DATA_W'(mode_ff) & ~RSVD_MASK;
    end
    else if (setupPh)
    begin
      prdata_ff <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Forwarding start point

  logic [LEN_W-1:0] fwdStart_ff;
  logic             fwdValid_ff;
  logic [LEN_W-1:0] nxt_fwdStart;
  logic [LEN_W-1:0] midPoint;
  logic [LEN_W-1:0] thrCycles;
  logic             bufferWhole;

  assign midPoint    = pktIn.lenCycles >> 1;
  assign thrCycles   = LEN_W'(mode_ff.ctThresh);
  assign bufferWhole = mode_ff.storeFwd
                     | (pktIn.nonPosted & mode_ff.nonPostedStoreFwd);

  always_comb
  begin
    if (bufferWhole)
    begin
      nxt_fwdStart = pktIn.lenCycles;
    end
    else if (pktIn.slowToFast)
    begin
      // Short packets saturate at zero rather than wrapping
      nxt_fwdStart = (midPoint > thrCycles) ? midPoint - thrCycles : '0;
    end
    else
    begin
      nxt_fwdStart = '0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fwdStart_ff <= '0;
      fwdValid_ff <= 1'b0;
    end
    else
    begin
      fwdValid_ff <= pktIn.valid;
      if (pktIn.valid)
      begin
        fwdStart_ff <= nxt_fwdStart;
      end
    end
  end

  assign fwdValid      = fwdValid_ff;
  assign fwdStartCycle = fwdStart_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Port arbiter

  logic [NPORT-1:0]  grant_ff;
  logic [NPORT-1:0]  nxt_grant;
  logic [PORT_W-1:0] ptr_ff;
  logic [PORT_W-1:0] nxt_ptr;
  logic              holdCur;
  int                pIdx;
  logic              pFound;

  // Stay mode ignores credit while the holder still requests
  assign holdCur = mode_ff.arbStay ? |(grant_ff & portReq)
                                   : |(grant_ff & portReq & portCreditOk);

  always_comb
  begin
    nxt_grant = grant_ff;
    nxt_ptr   = ptr_ff;
    pFound    = 1'b0;
    pIdx      = 0;
    if (!holdCur)
    begin
      nxt_grant = '0;
      for (int k = 1; k <= NPORT; k++)
      begin
        pIdx = (int'(ptr_ff) + k) % NPORT;
        if (!pFound && portReq[pIdx] && portCreditOk[pIdx])
        begin
          nxt_grant[pIdx] = 1'b1;
          nxt_ptr         = PORT_W'(pIdx);
          pFound          = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      grant_ff <= '0;
      ptr_ff   <= PORT_W'(NPORT - 1);
    end
    else
    begin
      grant_ff <= nxt_grant;
      ptr_ff   <= nxt_ptr;
    end
  end

  assign portGrant = grant_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Credit release

  logic [NCRED-1:0]  creditRel_ff;
  logic [NCRED-1:0]  nxt_creditRel;
  logic [CRED_W-1:0] typePtr_ff;
  logic [CRED_W-1:0] nxt_typePtr;
  int                cIdx;
  logic              cFound;

  always_comb
  begin
    nxt_creditRel = '0;
    nxt_typePtr   = typePtr_ff;
    cFound        = 1'b0;
    cIdx          = 0;
    if (mode_ff.creditAllTypes)
    begin
      nxt_creditRel = creditPend;
    end
    else
    begin
      // One type per update, rotating so no type starves
      for (int k = 1; k <= NCRED; k++)
      begin
        cIdx = (int'(typePtr_ff) + k) % NCRED;
        if (!cFound && creditPend[cIdx])
        begin
          nxt_creditRel[cIdx] = 1'b1;
          nxt_typePtr         = CRED_W'(cIdx);
          cFound              = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      creditRel_ff <= '0;
      typePtr_ff   <= CRED_W'(NCRED - 1);
    end
    else
    begin
      creditRel_ff <= nxt_creditRel;
      typePtr_ff   <= nxt_typePtr;
    end
  end

  assign creditRel = creditRel_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_thresh_reset: assert property (
    $fell(sys_rst) |-> mode_ff.ctThresh == CT_THRESH_RST && !mode_ff.arbStay
  ) else $error("threshold or arbitration mode wrong after reset");

  a_store_whole: assert property (
    pktIn.valid && mode_ff.storeFwd |=> fwdValid && fwdStartCycle == $past(pktIn.lenCycles)
  ) else $error("store mode did not wait for whole packet");

  a_nonposted_buf: assert property (
    pktIn.valid && !mode_ff.storeFwd && pktIn.nonPosted && !mode_ff.nonPostedStoreFwd
    && !pktIn.slowToFast |=> fwdStartCycle == '0
  ) else $error("non-posted packet not cut through");

  a_thresh_apply: assert property (
    pktIn.valid && !bufferWhole && pktIn.slowToFast && midPoint > thrCycles
    |=> fwdStartCycle == $past(midPoint) - $past(thrCycles)
  ) else $error("cut-through threshold misapplied");

  a_arb_stay: assert property (
    mode_ff.arbStay && |(grant_ff & portReq) |=> $stable(portGrant)
  ) else $error("stay mode left a requesting port");

  a_arb_credit: assert property (
    !holdCur && |nxt_grant |-> |(nxt_grant & portReq & portCreditOk) ##1 $onehot(portGrant)
  ) else $error("grant to port without credit");

  a_credit_all: assert property (
    mode_ff.creditAllTypes |=> creditRel == $past(creditPend)
  ) else $error("all-type update incomplete");

  a_credit_one: assert property (
    !mode_ff.creditAllTypes && |creditPend |=> $onehot(creditRel)
  ) else $error("per-type update released several types");

  a_ro_keep: assert property (
    wrEn && !autoLoadValid && !strapPending_ff
    |=> (DATA_W'(mode_ff) & RO_MASK) == (DATA_W'($past(mode_ff)) & RO_MASK)
  ) else $error("write altered read-only field");

  a_rsvd_zero: assert property (
    accessPh |-> !prdata[DATA_W-1] && !mode_ff.rsvd
  ) else $error("reserved bit not zero");

  a_load_take: assert property (
    autoLoadValid |=> DATA_W'(mode_ff) == ($past(autoLoadData) & LOAD_MASK)
  ) else $error("autoload value not taken");

  a_strap_take: assert property (
    $fell(sys_rst) ##0 !autoLoadValid
    |=> mode_ff.rxPolarityInvertOffStrap == $past(rxPolarityInvertOffStrap)
  ) else $error("strap level not captured");

endmodule : sfm_mode_ctrl
`default_nettype wire

// ---- pkg/sfm_pkg.sv ----
`default_nettype none
package sfm_pkg;

  localparam int ADDR_W   = 12;
  localparam int DATA_W   = 32;
  localparam int STRB_W   = DATA_W / 8;
  localparam int LEN_W    = 8;
  localparam int NPORT    = 3;
  localparam int PORT_W   = 2;
  localparam int NCRED    = 3;
  localparam int CRED_W   = 2;

  localparam logic [ADDR_W-1:0] MODE_OFFSET = 12'h074;

  // Software may change bits 13:0 only; bit 31 is reserved and held at zero
  localparam logic [DATA_W-1:0] SW_WR_MASK  = 32'h0000_3fff;
  localparam logic [DATA_W-1:0] LOAD_MASK   = 32'h7fff_ffff;
  localparam logic [DATA_W-1:0] RSVD_MASK   = 32'h8000_0000;
  localparam logic [DATA_W-1:0] RO_MASK     = 32'h7fff_c000;

  localparam logic [1:0] CT_THRESH_RST    = 2'h1;
  localparam logic [5:0] PM_PARAM_RST     = 6'h21;
  localparam logic [4:0] DRV_LOW_EMPH_RST = 5'h13;
  localparam logic [4:0] DRV_HIGH_EMPH_RST = 5'h13;
  localparam logic [4:0] DRV_HALF_RST     = 5'h02;
  localparam logic       STORE_FWD_RST    = 1'h0;

  typedef struct packed {
    logic       rsvd;
    logic [4:0] txDriveLevelHalfSwingDefault;
    logic [4:0] txDriveLevelHighEmphDefault;
    logic [4:0] txDriveLevelLowEmphDefault;
    logic       complParityOff;
    logic       rxPolarityInvertOffStrap;
    logic [5:0] pmParam;
    logic       nonPostedStoreFwd;
    logic       orderCplTags;
    logic       orderAcrossEgress;
    logic       creditAllTypes;
    logic       arbStay;
    logic [1:0] ctThresh;
    logic       storeFwd;
  } sfm_mode_t;

  localparam sfm_mode_t MODE_RST = '{
    rsvd: 1'h0,
    txDriveLevelHalfSwingDefault: DRV_HALF_RST,
    txDriveLevelHighEmphDefault: DRV_HIGH_EMPH_RST,
    txDriveLevelLowEmphDefault: DRV_LOW_EMPH_RST,
    complParityOff: 1'h0,
    rxPolarityInvertOffStrap: 1'h0,
    pmParam: PM_PARAM_RST,
    nonPostedStoreFwd: 1'h0,
    orderCplTags: 1'h0,
    orderAcrossEgress: 1'h0,
    creditAllTypes: 1'h0,
    arbStay: 1'h0,
    ctThresh: CT_THRESH_RST,
    storeFwd: STORE_FWD_RST
  };

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [STRB_W-1:0] pstrb;
  } sfm_apb_req_t;

  typedef struct packed {
    logic             valid;
    logic             nonPosted;
    logic             slowToFast;
    logic [LEN_W-1:0] lenCycles;
  } sfm_pkt_t;

endpackage : sfm_pkg
`default_nettype wire

// ---- verif/switch_forwarding_mode_config_test.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checkCount++; if ((g) !== (e)) begin failCount++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module switch_forwarding_mode_config_test;
  import sfm_pkg::*;
  logic                 clock;
  logic                 sys_rst;
  sfm_apb_req_t         bus;
  logic                 pready;
  logic                 pslverr;
  logic [DATA_W-1:0]    prdata;
  logic                 autoLoadValid;
  logic [DATA_W-1:0]    autoLoadData;
  logic                 strap;
  sfm_pkt_t             pkt;
  logic                 fwdValid;
  logic [LEN_W-1:0]     fwdStartCycle;
  logic [NPORT-1:0]     portReq;
  logic [NPORT-1:0]     portCreditOk;
  logic [NPORT-1:0]     portGrant;
  logic [NCRED-1:0]     creditPend;
  logic [NCRED-1:0]     creditRel;
  sfm_mode_t            modeOut;
  logic [DATA_W-1:0]    rd;
  logic                 err;
  int                   failCount;
  int                   checkCount;
  // Strap pin held high so the reset image shows bit 14 set
  localparam logic [31:0] RST_IMG = 32'h0a73_6102;

  sfm_mode_ctrl u_dut (.clock(clock), .sys_rst(sys_rst), .apbReq(bus), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .autoLoadValid(autoLoadValid),
    .autoLoadData(autoLoadData), .rxPolarityInvertOffStrap(strap), .pktIn(pkt),
    .fwdValid(fwdValid), .fwdStartCycle(fwdStartCycle), .portReq(portReq),
    .portCreditOk(portCreditOk), .portGrant(portGrant), .creditPend(creditPend),
    .creditRel(creditRel), .modeOut(modeOut));

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  //////////////////////////////////////////////////////////////////////////////
  task finalReport;
    $display("comparisons %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finalReport

  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  // Setup then access; request held until pready is seen high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int i;
    @(posedge clock);
    bus.psel <= 1'b1;
    bus.penable <= 1'b0;
    bus.pwrite <= wr;
    bus.paddr <= a;
    bus.pwdata <= d;
    bus.pstrb <= s;
    @(posedge clock);
    bus.penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clock);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
    begin
      failCount++;
      finalReport();
    end
    rd = prdata;
    err = pslverr;
    bus.psel <= 1'b0;
    bus.penable <= 1'b0;
  endtask : apb

  task sendPkt(input logic np, input logic s2f, input logic [7:0] len, input logic [7:0] e);
    @(posedge clock);
    pkt <= '{valid: 1'b1, nonPosted: np, slowToFast: s2f, lenCycles: len};
    @(posedge clock);
    pkt.valid <= 1'b0;
    #1;
    `CHK("fwdValid", 1'b1, fwdValid)
    `CHK("fwdStartCycle", e, fwdStartCycle)
  endtask : sendPkt

  task load(input logic [31:0] d);
    @(posedge clock);
    autoLoadValid <= 1'b1;
    autoLoadData <= d;
    @(posedge clock);
    autoLoadValid <= 1'b0;
  endtask : load

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    failCount = 0;
    checkCount = 0;
    sys_rst = 1'b1;
    bus = '0;
    autoLoadValid = 1'b0;
    autoLoadData = '0;
    strap = 1'b1;
    pkt = '0;
    portReq = '0;
    portCreditOk = '0;
    creditPend = '0;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;

    apb(1'b0, 12'h074, 32'h0, 4'hf);
    `CHK("reset image", RST_IMG, rd)
    `CHK("reset slverr", 1'b0, err)
    `CHK("modeOut reset", RST_IMG, 32'(modeOut))
    $display("test reset done");

    // Read-only and reserved bits must survive an all-ones write
    apb(1'b1, 12'h074, 32'hffff_ffff, 4'hf);
    apb(1'b0, 12'h074, 32'h0, 4'hf);
    `CHK("all ones", 32'h0a73_7fff, rd)
    apb(1'b1, 12'h074, 32'h0, 4'h2);
    apb(1'b0, 12'h074, 32'h0, 4'hf);
    `CHK("byte strobe", 32'h0a73_40ff, rd)
    apb(1'b1, 12'h078, 32'h0, 4'hf);
    `CHK("unmapped wr err", 1'b1, err)
    apb(1'b0, 12'h078, 32'h0, 4'hf);
    `CHK("unmapped rd err", 1'b1, err)
    `CHK("unmapped rd data", 32'h0, rd)
    apb(1'b0, 12'h074, 32'h0, 4'hf);
    `CHK("after unmapped", 32'h0a73_40ff, rd)
    $display("test access done");

    for (int t = 0; t < 4; t++)
    begin
      apb(1'b1, 12'h074, 32'(t) << 1, 4'hf);
      sendPkt(1'b0, 1'b1, 8'h14, 8'(10 - t));
    end
    sendPkt(1'b0, 1'b0, 8'h14, 8'h00);
    sendPkt(1'b0, 1'b1, 8'h04, 8'h00);
    sendPkt(1'b0, 1'b1, 8'h15, 8'h07);
    sendPkt(1'b1, 1'b1, 8'h15, 8'h07);
    sendPkt(1'b1, 1'b0, 8'h14, 8'h00);
    apb(1'b1, 12'h074, 32'h1, 4'hf);
    sendPkt(1'b0, 1'b1, 8'h14, 8'h14);
    sendPkt(1'b0, 1'b0, 8'h14, 8'h14);
    apb(1'b1, 12'h074, 32'h80, 4'hf);
    sendPkt(1'b1, 1'b1, 8'h14, 8'h14);
    sendPkt(1'b0, 1'b1, 8'h14, 8'h0a);
    $display("test forwarding done");

    apb(1'b1, 12'h074, 32'h60, 4'hf);
    tick(1);
    `CHK("ordering bits", 2'h3, {modeOut.orderCplTags, modeOut.orderAcrossEgress})
    `CHK("ordering word", 32'h0a73_4060, 32'(modeOut))

    // Default arbitration: grants follow credit; then stay mode keeps the grant without credit
    apb(1'b1, 12'h074, 32'h0, 4'hf);
    portReq <= 3'h1;
    portCreditOk <= 3'h1;
    tick(3);
    `CHK("grant p0", 3'h1, portGrant)
    @(posedge clock);
    portReq <= 3'h3;
    portCreditOk <= 3'h2;
    tick(3);
    `CHK("grant moves", 3'h2, portGrant)
    @(posedge clock);
    portCreditOk <= 3'h0;
    tick(3);
    `CHK("no credit", 3'h0, portGrant)
    apb(1'b1, 12'h074, 32'h8, 4'hf);
    portReq <= 3'h1;
    portCreditOk <= 3'h1;
    tick(3);
    `CHK("stay first", 3'h1, portGrant)
    @(posedge clock);
    portCreditOk <= 3'h0;
    tick(3);
    `CHK("stay grant", 3'h1, portGrant)
    @(posedge clock);
    portReq <= 3'h0;
    $display("test arbitration done");

    apb(1'b1, 12'h074, 32'h10, 4'hf);
    creditPend <= 3'h7;
    tick(2);
    `CHK("all types", 3'h7, creditRel)
    apb(1'b1, 12'h074, 32'h0, 4'hf);
    tick(1);
    `CHK("per type", 1'b1, $onehot(creditRel))
    @(posedge clock);
    creditPend <= 3'h0;
    $display("test credit done");

    load(32'hffff_ffff);
    apb(1'b0, 12'h074, 32'h0, 4'hf);
    `CHK("autoload ones", 32'h7fff_ffff, rd)
    load(32'h0);
    apb(1'b0, 12'h074, 32'h0, 4'hf);
    `CHK("autoload zero", 32'h0, rd)
    $display("test autoload done");

    // Second reset with the strap low: bit 14 must follow the pin
    @(posedge clock);
    strap <= 1'b0;
    sys_rst <= 1'b1;
    tick(3);
    @(posedge clock);
    sys_rst <= 1'b0;
    apb(1'b0, 12'h074, 32'h0, 4'hf);
    `CHK("strap low image", 32'h0a73_2102, rd)
    `CHK("strap low mode", 32'h0a73_2102, 32'(modeOut))
    $display("test strap done");
    finalReport();
  end
endmodule : switch_forwarding_mode_config_test
`undef CHK
`default_nettype wire
